// ===== design/ctim_cfg.svh
/*
 * Offsets, field positions, reset values and divider masks of the capture timer.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
`ifndef CTIM_CFG_SVH
`define CTIM_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CTIM_OFS_RELOAD   32'hFFFF_0380
`define CTIM_OFS_COUNT    32'hFFFF_0384
`define CTIM_OFS_CTRL     32'hFFFF_0388
`define CTIM_OFS_IRQCLR   32'hFFFF_038C
`define CTIM_OFS_CAPTURE  32'hFFFF_0390
`define CTIM_OFS_STATUS   32'hFFFF_0394
`define CTIM_OFS_MASK     32'hFFFF_0398

// ----------------------------------------------------------------------------
// Reset values and the control register write mask
// ----------------------------------------------------------------------------
`define CTIM_RST_RELOAD   16'h0000
`define CTIM_RST_COUNT    16'hFFFF
`define CTIM_RST_CTRL     32'h0000_0000
`define CTIM_RST_CAPTURE  16'h0000
`define CTIM_CTRL_WMASK   32'h0003_F3CF

// ----------------------------------------------------------------------------
// Prescaler codes and the matching terminal counts
// ----------------------------------------------------------------------------
`define CTIM_PRE_DIV1     4'h0
`define CTIM_PRE_DIV16    4'h4
`define CTIM_PRE_DIV256   4'h8
`define CTIM_PRE_DIV32K   4'hF
`define CTIM_PTC_DIV1     15'h0000
`define CTIM_PTC_DIV16    15'h000F
`define CTIM_PTC_DIV256   15'h00FF
`define CTIM_PTC_DIV32K   15'h7FFF

// ----------------------------------------------------------------------------
// Counter limits and status bit positions
// ----------------------------------------------------------------------------
`define CTIM_CNT_MAX      16'hFFFF
`define CTIM_CNT_MIN      16'h0000
`define CTIM_ST_TIMEOUT   0
`define CTIM_ST_CAPTURE   1

`endif

// ===== design/ctim_pkg.sv
/*
 * Types of the capture timer: control register layout and bus responses.
 * Assumes ctim_cfg.svh carries all numeric constants.
 */
package ctim_pkg;

	// ------------------------------------------------------------------------
	// Control register layout
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [13:0] rsvd_hi;
		logic        cap_en;
		logic [4:0]  evt_sel;
		logic [1:0]  rsvd_mid;
		logic        clk_sel;
		logic        count_up;
		logic        enable;
		logic        periodic;
		logic [1:0]  rsvd_lo;
		logic [3:0]  prescale;
	} ctim_ctrl_s;

	// ------------------------------------------------------------------------
	// Bus response codes
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CTIM_RESP_OKAY   = 2'h0,
		CTIM_RESP_SLVERR = 2'h2
	} ctim_resp_e;

endpackage : ctim_pkg

// ===== design/ctim_top.sv
/*
 * 16-bit up/down timer with prescaler, periodic reload, event capture,
 * sticky interrupt status and an AXI4-Lite register slave.
 * Assumes event sources run on aclk and the low-power oscillator is asynchronous.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ctim_cfg.svh"

module ctim_top (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address channel
	input  wire logic [31:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// Write data channel
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// Write response channel
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Read address channel
	input  wire logic [31:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// Read data channel
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Timer sources and events
	input  wire logic        lp_osc,
	input  wire logic [31:0] irq_sources,
	// Outputs to the system
	output logic             irq,
	output logic             serial_test_link
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	ctim_pkg::ctim_ctrl_s ctrl_q;
	logic [15:0] reload_q;
	logic [15:0] count_q;
	logic [15:0] capture_q;
	logic [1:0]  status_q;
	logic [1:0]  mask_q;
	logic [14:0] pre_q;
	logic [2:0]  osc_sync_q;
	logic        osc_lvl_q;
	logic        evt_prev_q;
	logic        irq_q;
	logic        stl_q;
	logic        aw_held_q;
	logic        w_held_q;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	// ------------------------------------------------------------------------
	// Byte lane mask
	// ------------------------------------------------------------------------
	logic [31:0] lane_mask;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_lane
			assign lane_mask[gi*8 +: 8] = {8{w_strb_q[gi]}};
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Write path decode
	// ------------------------------------------------------------------------
	// Commit once both halves are held; the bus may deliver them in either order
	wire aw_hs      = awvalid & awready_q;
	wire w_hs       = wvalid & wready_q;
	wire wr_go      = aw_held_q & w_held_q;
	wire wr_reload  = wr_go & (aw_addr_q == `CTIM_OFS_RELOAD);
	wire wr_ctrl    = wr_go & (aw_addr_q == `CTIM_OFS_CTRL);
	wire wr_irqclr  = wr_go & (aw_addr_q == `CTIM_OFS_IRQCLR);
	wire wr_status  = wr_go & (aw_addr_q == `CTIM_OFS_STATUS);
	wire wr_mask    = wr_go & (aw_addr_q == `CTIM_OFS_MASK);
	wire wr_ro      = (aw_addr_q == `CTIM_OFS_COUNT) | (aw_addr_q == `CTIM_OFS_CAPTURE);
	wire wr_hit     = wr_reload | wr_ctrl | wr_irqclr | wr_status | wr_mask;
	wire wr_bad     = wr_go & ~wr_hit & ~wr_ro;

	// Merged register values under byte enables
	wire [31:0] ctrl_mrg   = ((ctrl_q & ~lane_mask) | (w_data_q & lane_mask)) & `CTIM_CTRL_WMASK;
	wire [15:0] reload_mrg = (reload_q & ~lane_mask[15:0]) | (w_data_q[15:0] & lane_mask[15:0]);

	// Handshake next values; readies stay low while a response is pending
	wire aw_held_d = aw_held_q ? ~wr_go : aw_hs;
	wire w_held_d  = w_held_q ? ~wr_go : w_hs;
	wire bvalid_d  = wr_go | (bvalid_q & ~bready);
	wire awready_d = ~aw_held_d & ~bvalid_d;
	wire wready_d  = ~w_held_d & ~bvalid_d;

	// ------------------------------------------------------------------------
	// Read path decode
	// ------------------------------------------------------------------------
	wire ar_hs     = arvalid & arready_q;
	wire rvalid_d  = ar_hs | (rvalid_q & ~rready);
	wire arready_d = ~rvalid_d;
	wire rd_reload = (araddr == `CTIM_OFS_RELOAD);
	wire rd_count  = (araddr == `CTIM_OFS_COUNT);
	wire rd_ctrl   = (araddr == `CTIM_OFS_CTRL);
	wire rd_irqclr = (araddr == `CTIM_OFS_IRQCLR);
	wire rd_cap    = (araddr == `CTIM_OFS_CAPTURE);
	wire rd_status = (araddr == `CTIM_OFS_STATUS);
	wire rd_mask   = (araddr == `CTIM_OFS_MASK);
	wire rd_hit    = rd_reload | rd_count | rd_ctrl | rd_irqclr | rd_cap | rd_status | rd_mask;

	// Write-only clear register reads as zero
	wire [31:0] rd_mux =
		({32{rd_reload}} & {16'h0000, reload_q}) |
		({32{rd_count}}  & {16'h0000, count_q}) |
		({32{rd_ctrl}}   & ctrl_q) |
		({32{rd_cap}}    & {16'h0000, capture_q}) |
		({32{rd_status}} & {30'h0000_0000, status_q}) |
		({32{rd_mask}}   & {30'h0000_0000, mask_q});

	// ------------------------------------------------------------------------
	// Source clock selection and prescaler
	// ------------------------------------------------------------------------
	// Oscillator edge counts only once the second and third stages agree
	wire osc_agree = (osc_sync_q[1] == osc_sync_q[2]);
	wire osc_rise  = osc_agree & osc_sync_q[2] & ~osc_lvl_q;
	wire src_tick  = ctrl_q.clk_sel ? osc_rise : 1'b1;

	// Prescaler; undocumented codes fall back to divide by one
	wire [14:0] pre_tc =
		(ctrl_q.prescale == `CTIM_PRE_DIV16)  ? `CTIM_PTC_DIV16 :
		(ctrl_q.prescale == `CTIM_PRE_DIV256) ? `CTIM_PTC_DIV256 :
		(ctrl_q.prescale == `CTIM_PRE_DIV32K) ? `CTIM_PTC_DIV32K :
		`CTIM_PTC_DIV1;
	// Compare with >= so a shrinking divider cannot strand the count
	wire pre_done = (pre_q >= pre_tc);
	wire tick     = ctrl_q.enable & src_tick & pre_done;

	// ------------------------------------------------------------------------
	// Counter step
	// ------------------------------------------------------------------------
	wire at_term  = ctrl_q.count_up ? (count_q == `CTIM_CNT_MAX)
	                                : (count_q == `CTIM_CNT_MIN);
	wire timeout  = tick & at_term;
	wire [15:0] cnt_step = ctrl_q.count_up ? (count_q + 16'h0001)
	                                       : (count_q - 16'h0001);
	// Free-running wraps naturally through the step arithmetic
	wire [15:0] cnt_next = (timeout & ctrl_q.periodic) ? reload_q : cnt_step;

	// Event capture on a rising edge of the selected source
	wire evt_now  = irq_sources[ctrl_q.evt_sel];
	wire evt_rise = ctrl_q.cap_en & evt_now & ~evt_prev_q;

	// ------------------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------------------
	// Set wins over clear so an event in the clearing cycle survives
	wire [1:0] st_set = {evt_rise, timeout};
	wire [1:0] st_clr = ({2{wr_irqclr}}) |
	                    ({2{wr_status & w_strb_q[0]}} & w_data_q[1:0]);
	wire [1:0] status_d = st_set | (status_q & ~st_clr);

	// ------------------------------------------------------------------------
	// Oscillator synchroniser, prescaler and main counter
	// ------------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			osc_sync_q <= 3'h0;
			osc_lvl_q  <= 1'b0;
		end
		else
		begin
			osc_sync_q <= {osc_sync_q[1:0], lp_osc};
			if (osc_agree)
				osc_lvl_q <= osc_sync_q[2];
		end
	end

	// Held at zero while disabled so each start is a full period
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre_q <= 15'h0000;
		else if (!ctrl_q.enable)
			pre_q <= 15'h0000;
		else if (src_tick)
			pre_q <= pre_done ? 15'h0000 : pre_q + 15'h0001;
	end

	// A load register write also loads the counter and wins over a tick
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_q <= `CTIM_RST_COUNT;
		else if (wr_reload)
			count_q <= reload_mrg;
		else if (tick)
			count_q <= cnt_next;
	end

	// Capture register and event edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			capture_q  <= `CTIM_RST_CAPTURE;
			evt_prev_q <= 1'b0;
		end
		else
		begin
			evt_prev_q <= evt_now;
			if (evt_rise)
				capture_q <= count_q;
		end
	end

	// ------------------------------------------------------------------------
	// Software registers, status and outputs
	// ------------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q   <= `CTIM_RST_CTRL;
			reload_q <= `CTIM_RST_RELOAD;
			mask_q   <= 2'h0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= ctrl_mrg;
			if (wr_reload)
				reload_q <= reload_mrg;
			if (wr_mask & w_strb_q[0])
				mask_q <= w_data_q[1:0];
		end
	end

	// Link strobe is one cycle per timeout, the time base of that peripheral
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_q <= 2'h0;
			irq_q    <= 1'b0;
			stl_q    <= 1'b0;
		end
		else
		begin
			status_q <= status_d;
			irq_q    <= |(status_d & mask_q);
			stl_q    <= timeout;
		end
	end

	// ------------------------------------------------------------------------
	// Write channel holding
	// ------------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end
		else
		begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			if (aw_hs)
				aw_addr_q <= awaddr;
			if (w_hs)
			begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	// Write handshake and response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= ctim_pkg::CTIM_RESP_OKAY;
		end
		else
		begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			if (wr_go)
				bresp_q <= wr_bad ? ctim_pkg::CTIM_RESP_SLVERR : ctim_pkg::CTIM_RESP_OKAY;
		end
	end

	// ------------------------------------------------------------------------
	// Read handshake and data
	// ------------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= ctim_pkg::CTIM_RESP_OKAY;
		end
		else
		begin
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			if (ar_hs)
			begin
				rdata_q <= rd_mux;
				rresp_q <= rd_hit ? ctim_pkg::CTIM_RESP_OKAY : ctim_pkg::CTIM_RESP_SLVERR;
			end
		end
	end

	// Port drive straight from the registers
	assign awready          = awready_q;
	assign wready           = wready_q;
	assign bvalid           = bvalid_q;
	assign bresp            = bresp_q;
	assign arready          = arready_q;
	assign rvalid           = rvalid_q;
	assign rdata            = rdata_q;
	assign rresp            = rresp_q;
	assign irq              = irq_q;
	assign serial_test_link = stl_q;

endmodule : ctim_top

// ===== sim/ctim_props.sv
/*
 * Checker of the capture timer: bus handshakes, reset state, interrupt clear.
 * Assumes it is bound to ctim_top and sees only the top module's ports.
 */
`timescale 1ns/1ns
`include "ctim_cfg.svh"

module ctim_props (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write channels
	input wire logic [31:0] awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	// Read channels
	input wire logic [31:0] araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// System outputs
	input wire logic        irq,
	input wire logic        serial_test_link
);
	// ------------------------------------------------------------------------
	// Steps of a transfer
	// ------------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Address and data taken at one edge
	sequence s_wr_both;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	// Commit edge first, response one cycle later
	sequence s_wr_answer;
		!bvalid ##1 bvalid;
	endsequence

	// ------------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------------
	AST_WR_RESP: assert property (s_wr_both |=> s_wr_answer)
		else $error("write response not on time");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	AST_W_BUSY: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	AST_RD_RESP: assert property (s_rd_take |=> rvalid)
		else $error("read data not one cycle after address");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data changed before taken");
	AST_R_BUSY: assert property (rvalid |-> !arready)
		else $error("read address accepted while data pending");
	AST_RD_UNMAPPED: assert property (s_rd_take and araddr == 32'hFFFF_039C |=> rresp == 2'h2 && rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	AST_CLR_IRQ: assert property (s_wr_both and awaddr == `CTIM_OFS_IRQCLR |-> ##3 !irq)
		else $error("interrupt not cleared by clear write");
	AST_RESET_QUIET: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !irq && !serial_test_link && !arready)
		else $error("outputs not quiet after reset");
endmodule : ctim_props

bind ctim_top ctim_props i_ctim_props (
	.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready), .irq(irq), .serial_test_link(serial_test_link)
);

// ===== sim/ctim_top_tb.sv
/*
 * Self-checking bench of the capture timer over its AXI4-Lite port.
 * Assumes ctim_top, its package and ctim_props are compiled before it.
 */
`timescale 1ns/1ns
`include "ctim_cfg.svh"

module ctim_top_tb;
	// ------------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------------
	logic        aclk, aresetn, irq, stl;
	logic        lp_osc = 1'b0;
	logic [31:0] awaddr, wdata, araddr, rdata, irq_sources, a, b;
	logic [3:0]  wstrb;
	logic [2:0]  awprot, arprot;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          errors, cmp_count;
	int          cyc = 0, stl_n = 0, osc_cnt = 0;
	logic [3:0]  pre [4] = '{`CTIM_PRE_DIV1, `CTIM_PRE_DIV16, `CTIM_PRE_DIV256, `CTIM_PRE_DIV32K};
	int          dv [4] = '{1, 16, 256, 32768};

	ctim_top i_ctim_top (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .lp_osc(lp_osc), .irq_sources(irq_sources), .irq(irq), .serial_test_link(stl)
	);

	// Clock, slow oscillator of 20 cycles, pulse counter and hang guard
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		osc_cnt <= (osc_cnt == 9) ? 0 : osc_cnt + 1;
		if (osc_cnt == 9) lp_osc <= ~lp_osc;
		if (stl) stl_n <= stl_n + 1;
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			errors++;
			results();
		end
	end

	// ------------------------------------------------------------------------
	// Bus tasks and comparisons
	// ------------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// In-range test; an unknown value never lands in range
	task automatic rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		chk(v, ((v >= lo) && (v <= hi)) === 1'b1 ? v : lo);
	endtask : rng

	task automatic wr(input logic [31:0] ad, input logic [31:0] d, input logic [1:0] rs = 2'h0);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid)
			begin
				bready <= 1'b0;
				chk({30'h0, bresp}, {30'h0, rs});
				done = 1'b1;
			end
		end
	endtask : wr

	task automatic rd(input logic [31:0] ad, output logic [31:0] d, input logic [1:0] rs = 2'h0);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid)
			begin
				rready <= 1'b0;
				d = rdata;
				chk({30'h0, rresp}, {30'h0, rs});
				done = 1'b1;
			end
		end
	endtask : rd

	task automatic rdc(input logic [31:0] ad, input logic [31:0] exp);
		logic [31:0] v;
		rd(ad, v);
		chk(v, exp);
	endtask : rdc

	// Count advance over a fixed wait, from a count of 0x100
	task automatic meas(input logic [31:0] ctl, input int w, input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] c0, c1, d;
		wr(`CTIM_OFS_RELOAD, 32'h0000_0100);
		wr(`CTIM_OFS_CTRL, ctl);
		rd(`CTIM_OFS_COUNT, c0);
		repeat (w) @(posedge aclk);
		rd(`CTIM_OFS_COUNT, c1);
		d = ctl[8] ? c1 - c0 : c0 - c1;
		rng({16'h0000, d[15:0]}, lo, hi);
	endtask : meas

	task automatic pulse(input logic [31:0] v);
		@(posedge aclk);
		irq_sources <= v;
		repeat (2) @(posedge aclk);
		irq_sources <= 32'h0000_0000;
	endtask : pulse

	task automatic results();
		if (errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// ------------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------------
	initial
	begin
		{aresetn, awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awprot, arprot, irq_sources, errors, cmp_count} = '0;
		wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, refusals and read-only places
		rdc(`CTIM_OFS_RELOAD, 32'h0000_0000);
		rdc(`CTIM_OFS_COUNT, 32'h0000_FFFF);
		rdc(`CTIM_OFS_CTRL, 32'h0000_0000);
		rdc(`CTIM_OFS_CAPTURE, 32'h0000_0000);
		wr(32'hFFFF_039C, 32'h0000_0001, 2'h2);
		rd(32'hFFFF_039C, a, 2'h2);
		chk(a, 32'h0000_0000);
		wr(`CTIM_OFS_COUNT, 32'h0000_5555);
		rdc(`CTIM_OFS_COUNT, 32'h0000_FFFF);
		wr(`CTIM_OFS_CTRL, 32'hFFFF_FFFF);
		rdc(`CTIM_OFS_CTRL, `CTIM_CTRL_WMASK);
		wr(`CTIM_OFS_CTRL, 32'h0000_0000);
		wr(`CTIM_OFS_RELOAD, 32'h0000_1234);
		rdc(`CTIM_OFS_RELOAD, 32'h0000_1234);
		rdc(`CTIM_OFS_COUNT, 32'h0000_1234);
		// Direction, enable, clock source and each of the four named prescaler codes
		meas(32'h0000_0100, 40, 32'h0, 32'h0);
		meas(32'h0000_0080, 16, 32'd16, 32'd24);
		meas(32'h0000_0380, 200, 32'd9, 32'd12);
		for (int i = 0; i < 4; i++)
			meas(32'h0000_0180 | pre[i], 2 * dv[i], 32'd2, (i == 0) ? 32'd10 : 32'd3);
		// Periodic reload: six ticks a period, interrupt and clear
		// Stop first so the prescaler phase is known at the start
		wr(`CTIM_OFS_CTRL, 32'h0000_0000);
		wr(`CTIM_OFS_MASK, 32'h0000_0001);
		wr(`CTIM_OFS_RELOAD, 32'h0000_0005);
		wr(`CTIM_OFS_CTRL, 32'h0000_00C0);
		a = stl_n;
		repeat (60) @(posedge aclk);
		chk(stl_n - a, 32'd9);
		chk({31'h0, irq}, 32'h1);
		rd(`CTIM_OFS_COUNT, b);
		rng(b, 32'h0, 32'h5);
		wr(`CTIM_OFS_CTRL, 32'h0000_0000);
		rdc(`CTIM_OFS_STATUS, 32'h0000_0001);
		wr(`CTIM_OFS_IRQCLR, 32'h0000_00A5);
		rdc(`CTIM_OFS_STATUS, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0);
		// Free-running wrap with the interrupt masked, then unmasked
		wr(`CTIM_OFS_MASK, 32'h0000_0000);
		wr(`CTIM_OFS_RELOAD, 32'h0000_0002);
		wr(`CTIM_OFS_CTRL, 32'h0000_0080);
		repeat (10) @(posedge aclk);
		rd(`CTIM_OFS_COUNT, a);
		rng(a, 32'h0000_FFF0, 32'h0000_FFFF);
		wr(`CTIM_OFS_CTRL, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0);
		wr(`CTIM_OFS_MASK, 32'h0000_0001);
		@(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(`CTIM_OFS_STATUS, 32'h0000_0001);
		rdc(`CTIM_OFS_STATUS, 32'h0000_0000);
		// Capture from each of the 32 sources, frozen count as marker
		for (int s = 0; s < 32; s++)
		begin
			wr(`CTIM_OFS_RELOAD, 32'h0000_0040 + s);
			wr(`CTIM_OFS_CTRL, 32'h0002_0000 | (s << 12));
			pulse(32'h0000_0001 << s);
			rdc(`CTIM_OFS_CAPTURE, 32'h0000_0040 + s);
		end
		rdc(`CTIM_OFS_STATUS, 32'h0000_0002);
		wr(`CTIM_OFS_RELOAD, 32'h0000_0077);
		wr(`CTIM_OFS_CTRL, 32'h0000_3000);
		pulse(32'h0000_0008);
		rdc(`CTIM_OFS_CAPTURE, 32'h0000_005F);
		wr(`CTIM_OFS_CTRL, 32'h0002_5000);
		pulse(32'h0000_0040);
		rdc(`CTIM_OFS_CAPTURE, 32'h0000_005F);
		// Capture while counting: count keeps moving on
		wr(`CTIM_OFS_RELOAD, 32'h0000_0100);
		wr(`CTIM_OFS_CTRL, 32'h0002_5180);
		pulse(32'h0000_0020);
		rd(`CTIM_OFS_CAPTURE, a);
		rd(`CTIM_OFS_COUNT, b);
		rng({16'h0000, b[15:0] - a[15:0]}, 32'd1, 32'd40);
		rng(a, 32'h0000_0101, 32'h0000_0120);
		results();
	end
endmodule : ctim_top_tb
